/* File: hdl/hpb_regs.sv */
`timescale 1ns/10ps
module hpb_regs (
    input  wire logic        core_clk,
    input  wire logic        reset,
    input  wire logic        cs_n,
    input  wire logic        rd_n,
    input  wire logic        wr_n,
    input  wire logic [1:0]  lane_en_n,
    input  wire logic [7:0]  addr,
    input  wire logic [15:0] data_in,
    output logic      [15:0] data_out,
    output logic             data_oe,
    output logic             irq_out_n,
    output logic             transceiver_macro_reset,
    output logic             little_endian_active,
    output logic             bus_width_select,
    output logic             strobe_or_byte_enable_select,
    output logic      [7:0]  clock_input_select,
    output logic      [1:0]  power_state
);

    typedef struct packed {
        hpb_pkg::hpb_power_t pstate;
        logic                strobe_seen;
        logic [7:0]          main_irq_status;
        logic [7:0]          main_irq_enable;
        logic [7:0]          chip_reset_ctrl;
        logic [7:0]          power_mgmt_ctrl;
        logic [15:0]         wakeup_timer;
        logic [7:0]          clock_select_protect;
        logic [7:0]          clock_input_select;
        logic [7:0]          host_bus_config;
        logic                endian_little;
        logic [15:0]         area0_start_address;
        logic [7:0]          endpoint_a_irq_enable;
        logic [7:0]          endpoint_b_irq_enable;
        logic [15:0]         data_out;
        logic                data_oe;
        logic                irq_out_n;
    } hpb_state_t;

    localparam hpb_state_t STATE_RST = '{
        pstate:                hpb_pkg::HPB_BUS_CUT,
        strobe_seen:           1'b0,
        main_irq_status:       hpb_pkg::BYTE_ZERO,
        main_irq_enable:       hpb_pkg::BYTE_ZERO,
        chip_reset_ctrl:       hpb_pkg::CHIP_RESET_RST,
        power_mgmt_ctrl:       hpb_pkg::BYTE_ZERO,
        wakeup_timer:          hpb_pkg::WORD_ZERO,
        clock_select_protect:  hpb_pkg::PROTECT_RST,
        clock_input_select:    hpb_pkg::CLK_OSC_12,
        host_bus_config:       hpb_pkg::BYTE_ZERO,
        endian_little:         1'b0,
        area0_start_address:   hpb_pkg::WORD_ZERO,
        endpoint_a_irq_enable: hpb_pkg::BYTE_ZERO,
        endpoint_b_irq_enable: hpb_pkg::BYTE_ZERO,
        data_out:              hpb_pkg::WORD_ZERO,
        data_oe:               1'b0,
        irq_out_n:             1'b1
    };

    hpb_state_t st;
    hpb_state_t next_st;

    hpb_feed_if fi ();

    ////////////////////////////////////////////////////////////////////////////
    // Address decode helpers

    function automatic logic is_word_reg(input logic [7:0] a);
        logic [7:0] even;
        even = {a[7:1], 1'b0};
        return (even == hpb_pkg::ADDR_WAKEUP_TIMER_HI) || (even == hpb_pkg::ADDR_AREA0_HI);
    endfunction

    function automatic logic is_sync_reg(input logic [7:0] a);
        return (a == hpb_pkg::ADDR_AREA0_HI) || (a == hpb_pkg::ADDR_AREA0_LO) ||
               (a == hpb_pkg::ADDR_EP_A_IRQ_ENABLE) || (a == hpb_pkg::ADDR_EP_B_IRQ_ENABLE);
    endfunction

    // Bus cut blocks everything; the synchronous group needs the Active clock
    function automatic logic reachable(input hpb_pkg::hpb_power_t ps, input logic [7:0] a);
        if (ps == hpb_pkg::HPB_BUS_CUT) begin
            return 1'b0;
        end
        return !is_sync_reg(a) || (ps == hpb_pkg::HPB_ACTIVE);
    endfunction

    function automatic logic [7:0] read_byte(input hpb_state_t s, input logic [7:0] a);
        logic [7:0] v;
        v = hpb_pkg::BYTE_ZERO;
        case (a)
            hpb_pkg::ADDR_MAIN_IRQ_STATUS: v = s.main_irq_status & hpb_pkg::IRQ_STATUS_MASK;
            hpb_pkg::ADDR_MAIN_IRQ_ENABLE: v = s.main_irq_enable;
            hpb_pkg::ADDR_CHIP_RESET_CTRL: v = s.chip_reset_ctrl;
            hpb_pkg::ADDR_POWER_MGMT_CTRL:
                v = (s.power_mgmt_ctrl & ~hpb_pkg::PM_STATE_MASK) | {6'h00, s.pstate};
            hpb_pkg::ADDR_WAKEUP_TIMER_HI: v = s.wakeup_timer[15:8];
            hpb_pkg::ADDR_WAKEUP_TIMER_LO: v = s.wakeup_timer[7:0];
            hpb_pkg::ADDR_CLOCK_PROTECT:   v = s.clock_select_protect;
            hpb_pkg::ADDR_CLOCK_SELECT:    v = s.clock_input_select;
            hpb_pkg::ADDR_BUS_CONFIG_LE,
            hpb_pkg::ADDR_BUS_CONFIG:      v = s.host_bus_config;
            hpb_pkg::ADDR_AREA0_HI:        v = s.area0_start_address[15:8];
            hpb_pkg::ADDR_AREA0_LO:        v = s.area0_start_address[7:0];
            hpb_pkg::ADDR_EP_A_IRQ_ENABLE: v = s.endpoint_a_irq_enable;
            hpb_pkg::ADDR_EP_B_IRQ_ENABLE: v = s.endpoint_b_irq_enable;
            default:                       v = hpb_pkg::BYTE_ZERO;
        endcase
        return reachable(s.pstate, a) ? v : hpb_pkg::BYTE_ZERO;
    endfunction

    function automatic logic clock_code_ok(input logic [7:0] c);
        case (c)
            hpb_pkg::CLK_OSC_12, hpb_pkg::CLK_EXT_12,
            hpb_pkg::CLK_OSC_24, hpb_pkg::CLK_EXT_24,
            hpb_pkg::CLK_EXT_48: return 1'b1;
            default:             return 1'b0;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Lane mapping

    logic       strobe;
    logic       acc_start;
    logic       narrow;
    logic [7:0] even_addr;
    logic [7:0] odd_addr;
    logic [7:0] lane_addr [2];
    logic [1:0] lane_we;

    assign strobe    = !cs_n && (!rd_n || !wr_n);
    assign acc_start = strobe && !st.strobe_seen;
    assign narrow    = st.host_bus_config[hpb_pkg::CFG_BUS_WIDTH_BIT];
    assign even_addr = {addr[7:1], 1'b0};
    assign odd_addr  = {addr[7:1], 1'b1};

    always_comb begin
        if (narrow) begin
            lane_addr[hpb_pkg::LANE_LO] = addr;
            lane_addr[hpb_pkg::LANE_HI] = addr;
        end else if (is_word_reg(addr) || !st.endian_little) begin
            // Word registers keep the high byte on the upper lane either way
            lane_addr[hpb_pkg::LANE_HI] = even_addr;
            lane_addr[hpb_pkg::LANE_LO] = odd_addr;
        end else begin
            lane_addr[hpb_pkg::LANE_HI] = odd_addr;
            lane_addr[hpb_pkg::LANE_LO] = even_addr;
        end
    end

    for (genvar l = 0; l < 2; l++) begin : g_lane
        assign lane_we[l] = acc_start && !wr_n && !lane_en_n[l] && (!narrow || l == 0);
    end

    ////////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        next_st             = st;
        next_st.strobe_seen = strobe;
        next_st.data_oe     = !cs_n && !rd_n && wr_n;
        if (narrow) begin
            next_st.data_out = {hpb_pkg::BYTE_ZERO, read_byte(st, addr)};
        end else begin
            next_st.data_out = {read_byte(st, lane_addr[hpb_pkg::LANE_HI]),
                                read_byte(st, lane_addr[hpb_pkg::LANE_LO])};
        end

        // Upper lane first so a low-lane alias write wins
        for (int l = 1; l >= 0; l--) begin
            if (lane_we[l] && reachable(st.pstate, lane_addr[l])) begin
                case (lane_addr[l])
                    hpb_pkg::ADDR_MAIN_IRQ_STATUS: begin
                        if (data_in[8*l+hpb_pkg::FEED_DONE_BIT]) begin
                            next_st.main_irq_status[hpb_pkg::FEED_DONE_BIT] = 1'b0;
                        end
                    end
                    hpb_pkg::ADDR_MAIN_IRQ_ENABLE: next_st.main_irq_enable = data_in[8*l+:8];
                    hpb_pkg::ADDR_CHIP_RESET_CTRL: next_st.chip_reset_ctrl = data_in[8*l+:8];
                    hpb_pkg::ADDR_POWER_MGMT_CTRL: next_st.power_mgmt_ctrl = data_in[8*l+:8];
                    hpb_pkg::ADDR_WAKEUP_TIMER_HI: next_st.wakeup_timer[15:8] = data_in[8*l+:8];
                    hpb_pkg::ADDR_WAKEUP_TIMER_LO: next_st.wakeup_timer[7:0] = data_in[8*l+:8];
                    hpb_pkg::ADDR_CLOCK_PROTECT:
                        next_st.clock_select_protect = data_in[8*l+:8];
                    hpb_pkg::ADDR_CLOCK_SELECT: begin
                        if (st.clock_select_protect == hpb_pkg::PROTECT_KEY) begin
                            next_st.clock_input_select = data_in[8*l+:8];
                        end
                    end
                    hpb_pkg::ADDR_BUS_CONFIG_LE,
                    hpb_pkg::ADDR_BUS_CONFIG:
                        next_st.host_bus_config = data_in[8*l+:8] & hpb_pkg::CFG_MASK;
                    hpb_pkg::ADDR_AREA0_HI:
                        next_st.area0_start_address[15:8] =
                            data_in[8*l+:8] & hpb_pkg::AREA0_MASK[15:8];
                    hpb_pkg::ADDR_AREA0_LO:
                        next_st.area0_start_address[7:0] =
                            data_in[8*l+:8] & hpb_pkg::AREA0_MASK[7:0];
                    hpb_pkg::ADDR_EP_A_IRQ_ENABLE:
                        next_st.endpoint_a_irq_enable = data_in[8*l+:8] & hpb_pkg::EP_IRQ_MASK;
                    hpb_pkg::ADDR_EP_B_IRQ_ENABLE:
                        next_st.endpoint_b_irq_enable = data_in[8*l+:8] & hpb_pkg::EP_IRQ_MASK;
                    default: begin
                    end
                endcase
            end
        end

        // Read side effects act once per strobe, at its leading edge
        if (acc_start && !rd_n) begin
            if (st.pstate == hpb_pkg::HPB_BUS_CUT &&
                (lane_addr[hpb_pkg::LANE_HI] == hpb_pkg::ADDR_POWER_MGMT_CTRL ||
                 lane_addr[hpb_pkg::LANE_LO] == hpb_pkg::ADDR_POWER_MGMT_CTRL)) begin
                next_st.pstate = hpb_pkg::HPB_SLEEP;
            end
            if (st.pstate != hpb_pkg::HPB_BUS_CUT &&
                (lane_addr[hpb_pkg::LANE_HI] == hpb_pkg::ADDR_ENDIAN_COMMIT ||
                 lane_addr[hpb_pkg::LANE_LO] == hpb_pkg::ADDR_ENDIAN_COMMIT)) begin
                next_st.endian_little = st.host_bus_config[hpb_pkg::CFG_ENDIAN_BIT];
            end
        end

        case (st.pstate)
            hpb_pkg::HPB_BUS_CUT, hpb_pkg::HPB_ACTIVE: begin
            end
            hpb_pkg::HPB_SLEEP: begin
                if (next_st.power_mgmt_ctrl[hpb_pkg::ACTIVATE_BIT] &&
                    !st.chip_reset_ctrl[hpb_pkg::MACRO_RESET_BIT]) begin
                    next_st.pstate = hpb_pkg::HPB_WAKING;
                end
            end
            hpb_pkg::HPB_WAKING: begin
                if (st.chip_reset_ctrl[hpb_pkg::MACRO_RESET_BIT]) begin
                    next_st.pstate = hpb_pkg::HPB_SLEEP;
                end else if (fi.done) begin
                    next_st.pstate = hpb_pkg::HPB_ACTIVE;
                end
            end
            default: next_st.pstate = hpb_pkg::HPB_BUS_CUT;
        endcase

        // Set after the clear so a same-cycle completion is not lost
        if (fi.done) begin
            next_st.main_irq_status[hpb_pkg::FEED_DONE_BIT] = 1'b1;
        end
        next_st.irq_out_n = !(next_st.main_irq_status[hpb_pkg::FEED_DONE_BIT] &&
                              next_st.main_irq_enable[hpb_pkg::FEED_DONE_BIT]);
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            st <= STATE_RST;
        end else begin
            st <= next_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Clock feed sequencer

    assign fi.start      = (st.pstate == hpb_pkg::HPB_WAKING) && !fi.running && !fi.done;
    assign fi.hold       = st.chip_reset_ctrl[hpb_pkg::MACRO_RESET_BIT];
    assign fi.wake_count = st.wakeup_timer;
    assign fi.clock_ok   = clock_code_ok(st.clock_input_select);

    hpb_clock_feed u_feed (
        .core_clk (core_clk),
        .reset    (reset),
        .fi       (fi.feed)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Outputs

    assign data_out                     = st.data_out;
    assign data_oe                      = st.data_oe;
    assign irq_out_n                    = st.irq_out_n;
    assign transceiver_macro_reset      = st.chip_reset_ctrl[hpb_pkg::MACRO_RESET_BIT];
    assign little_endian_active         = st.endian_little;
    assign bus_width_select             = st.host_bus_config[hpb_pkg::CFG_BUS_WIDTH_BIT];
    assign strobe_or_byte_enable_select = st.host_bus_config[hpb_pkg::CFG_BUS_MODE_BIT];
    assign clock_input_select           = st.clock_input_select;
    assign power_state                  = st.pstate;

endmodule

/* File: hdl/hpb_pkg.sv */
package hpb_pkg;

    localparam int ADDR_W = 8;
    localparam int DATA_W = 16;

    // Register byte addresses
    localparam logic [7:0] ADDR_MAIN_IRQ_STATUS = 8'h00;
    localparam logic [7:0] ADDR_MAIN_IRQ_ENABLE = 8'h08;
    localparam logic [7:0] ADDR_CHIP_RESET_CTRL = 8'h11;
    localparam logic [7:0] ADDR_POWER_MGMT_CTRL = 8'h12;
    localparam logic [7:0] ADDR_WAKEUP_TIMER_HI = 8'h14;
    localparam logic [7:0] ADDR_WAKEUP_TIMER_LO = 8'h15;
    localparam logic [7:0] ADDR_CLOCK_PROTECT   = 8'h71;
    localparam logic [7:0] ADDR_CLOCK_SELECT    = 8'h73;
    localparam logic [7:0] ADDR_BUS_CONFIG_LE   = 8'h74;
    localparam logic [7:0] ADDR_BUS_CONFIG      = 8'h75;
    localparam logic [7:0] ADDR_ENDIAN_COMMIT   = 8'h77;
    localparam logic [7:0] ADDR_AREA0_HI        = 8'h80;
    localparam logic [7:0] ADDR_AREA0_LO        = 8'h81;
    localparam logic [7:0] ADDR_EP_A_IRQ_ENABLE = 8'hC6;
    localparam logic [7:0] ADDR_EP_B_IRQ_ENABLE = 8'hC7;

    // Field positions
    localparam int CFG_BUS_WIDTH_BIT  = 0;
    localparam int CFG_BUS_MODE_BIT   = 1;
    localparam int CFG_ENDIAN_BIT     = 2;
    localparam int MACRO_RESET_BIT    = 7;
    localparam int ACTIVATE_BIT       = 6;
    localparam int FEED_DONE_BIT      = 0;
    localparam int LANE_HI            = 1;
    localparam int LANE_LO            = 0;

    // Field masks
    localparam logic [7:0]  CFG_MASK        = 8'h07;
    localparam logic [7:0]  IRQ_STATUS_MASK = 8'h01;
    localparam logic [15:0] AREA0_MASK      = 16'h1FFC;
    localparam logic [7:0]  EP_IRQ_MASK     = 8'h7F;
    localparam logic [7:0]  PM_STATE_MASK   = 8'h03;

    // Reset values
    localparam logic [7:0]  CHIP_RESET_RST  = 8'h80;
    localparam logic [7:0]  PROTECT_RST     = 8'h56;
    localparam logic [7:0]  BYTE_ZERO       = 8'h00;
    localparam logic [15:0] WORD_ZERO       = 16'h0000;

    localparam logic [7:0]  PROTECT_KEY     = 8'h56;

    // Clock select codes
    localparam logic [7:0] CLK_OSC_12 = 8'h00;
    localparam logic [7:0] CLK_EXT_12 = 8'h80;
    localparam logic [7:0] CLK_OSC_24 = 8'h01;
    localparam logic [7:0] CLK_EXT_24 = 8'h81;
    localparam logic [7:0] CLK_EXT_48 = 8'h83;

    // Wake-up timer unit
    localparam int CLK_PERIOD_NS    = 5;
    localparam int WAKE_TICK_NS     = 1000;
    localparam int WAKE_TICK_CYCLES = (WAKE_TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [7:0] TICK_LAST = 8'(WAKE_TICK_CYCLES - 1);

    typedef enum logic [1:0] {
        HPB_BUS_CUT,
        HPB_SLEEP,
        HPB_WAKING,
        HPB_ACTIVE
    } hpb_power_t;

    typedef enum logic [1:0] {
        HPB_FEED_IDLE,
        HPB_FEED_WAIT,
        HPB_FEED_DONE
    } hpb_feed_state_t;

endpackage

/* File: hdl/hpb_feed_if.sv */
`timescale 1ns/10ps
interface hpb_feed_if;
    logic        start;
    logic        hold;
    logic [15:0] wake_count;
    logic        clock_ok;
    logic        done;
    logic        running;

    modport ctrl (output start, output hold, output wake_count, output clock_ok,
                  input done, input running);
    modport feed (input start, input hold, input wake_count, input clock_ok,
                  output done, output running);
endinterface

/* File: hdl/hpb_clock_feed.sv */
`timescale 1ns/10ps
module hpb_clock_feed (
    input  wire logic  core_clk,
    input  wire logic  reset,
    hpb_feed_if.feed   fi
);

    typedef struct packed {
        hpb_pkg::hpb_feed_state_t state;
        logic [7:0]               tick;
        logic [15:0]              remain;
        logic                     done;
    } hpb_feed_reg_t;

    hpb_feed_reg_t st;
    hpb_feed_reg_t next_st;

    ////////////////////////////////////////////////////////////////////////////

    always_comb begin
        next_st      = st;
        next_st.done = 1'b0;
        case (st.state)
            hpb_pkg::HPB_FEED_IDLE: begin
                if (fi.start && !fi.hold) begin
                    next_st.state  = hpb_pkg::HPB_FEED_WAIT;
                    next_st.tick   = hpb_pkg::TICK_LAST;
                    next_st.remain = fi.wake_count;
                end
            end
            hpb_pkg::HPB_FEED_WAIT: begin
                // Bad clock source: the oscillator never settles, so no done
                if (fi.hold) begin
                    next_st.state = hpb_pkg::HPB_FEED_IDLE;
                end else if (fi.clock_ok) begin
                    if (st.remain == hpb_pkg::WORD_ZERO) begin
                        next_st.state = hpb_pkg::HPB_FEED_DONE;
                    end else if (st.tick == 8'h00) begin
                        next_st.tick   = hpb_pkg::TICK_LAST;
                        next_st.remain = st.remain - 16'h0001;
                    end else begin
                        next_st.tick = st.tick - 8'h01;
                    end
                end
            end
            hpb_pkg::HPB_FEED_DONE: begin
                next_st.done  = 1'b1;
                next_st.state = hpb_pkg::HPB_FEED_IDLE;
            end
            default: begin
                next_st.state = hpb_pkg::HPB_FEED_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            st <= '{state: hpb_pkg::HPB_FEED_IDLE, tick: hpb_pkg::BYTE_ZERO,
                    remain: hpb_pkg::WORD_ZERO, done: 1'b0};
        end else begin
            st <= next_st;
        end
    end

    assign fi.done    = st.done;
    assign fi.running = (st.state != hpb_pkg::HPB_FEED_IDLE);

endmodule

/* File: dv/hpb_regs_assertions.sv */
`timescale 1ns/10ps
module hpb_regs_assertions (
    input wire logic        core_clk,
    input wire logic        reset,
    input wire logic        cs_n,
    input wire logic        rd_n,
    input wire logic        wr_n,
    input wire logic [1:0]  lane_en_n,
    input wire logic [7:0]  addr,
    input wire logic [15:0] data_in,
    input wire logic [15:0] data_out,
    input wire logic        data_oe,
    input wire logic        irq_out_n,
    input wire logic        transceiver_macro_reset,
    input wire logic        little_endian_active,
    input wire logic        bus_width_select,
    input wire logic        strobe_or_byte_enable_select,
    input wire logic [7:0]  clock_input_select,
    input wire logic [1:0]  power_state
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);
    ////////////////////////////////////////////////////////////////////////////////
    property p_oe_on; !cs_n && !rd_n && wr_n |=> data_oe; endproperty
    a_oe_on: assert property (p_oe_on) else $error("read not driven");
    property p_oe_off; cs_n || rd_n || !wr_n |=> !data_oe; endproperty
    a_oe_off: assert property (p_oe_off) else $error("data driven outside read");
    // Output register lags one cycle, so judge by the previous power state
    property p_cut_zero; data_oe && $past(power_state) == 2'h0 |-> data_out == 16'h0000; endproperty
    a_cut_zero: assert property (p_cut_zero) else $error("bus cut read not zero");
    property p_cut_exit; power_state == 2'h0 && !cs_n && !rd_n && wr_n && addr[7:1] == 7'h09
        |=> power_state == 2'h1; endproperty
    a_cut_exit: assert property (p_cut_exit) else $error("bus cut not left");
    property p_cut_stay; power_state == 2'h0 && (cs_n || rd_n || addr[7:1] != 7'h09)
        |=> power_state == 2'h0; endproperty
    a_cut_stay: assert property (p_cut_stay) else $error("bus cut left early");
    property p_sel_write; $changed(clock_input_select) |-> $past(!cs_n && !wr_n); endproperty
    a_sel_write: assert property (p_sel_write) else $error("clock select moved");
    property p_macro_write; $changed(transceiver_macro_reset) |-> $past(!cs_n && !wr_n); endproperty
    a_macro_write: assert property (p_macro_write) else $error("macro reset moved");
    property p_endian_read; $changed(little_endian_active) |-> $past(!cs_n && !rd_n); endproperty
    a_endian_read: assert property (p_endian_read) else $error("endian moved");
    property p_active; $changed(power_state) && power_state == 2'h3 |-> $past(power_state) == 2'h2;
    endproperty
    a_active: assert property (p_active) else $error("active not from waking");
endmodule
bind hpb_regs hpb_regs_assertions hpb_regs_assertions_inst (
    .core_clk(core_clk), .reset(reset), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n),
    .lane_en_n(lane_en_n), .addr(addr), .data_in(data_in), .data_out(data_out),
    .data_oe(data_oe), .irq_out_n(irq_out_n),
    .transceiver_macro_reset(transceiver_macro_reset),
    .little_endian_active(little_endian_active), .bus_width_select(bus_width_select),
    .strobe_or_byte_enable_select(strobe_or_byte_enable_select),
    .clock_input_select(clock_input_select), .power_state(power_state));

/* File: dv/hpb_host_model.sv */
`timescale 1ns/10ps
module hpb_host_model (
    input  wire logic        core_clk,
    input  wire logic [15:0] data_out,
    output logic             cs_n,
    output logic             rd_n,
    output logic             wr_n,
    output logic      [1:0]  lane_en_n,
    output logic      [7:0]  addr,
    output logic      [15:0] data_in
);
    initial begin
        cs_n = 1'b1;
        rd_n = 1'b1;
        wr_n = 1'b1;
        lane_en_n = 2'b11;
        addr = 8'h00;
        data_in = 16'h0000;
    end
    // Strobe held three edges, then one idle cycle; released address and data lines show the inverse
    task automatic access(input logic [7:0] a, input logic [15:0] d, input logic [1:0] l,
                          input logic w, output logic [15:0] q);
        @(posedge core_clk);
        cs_n <= 1'b0;
        rd_n <= w;
        wr_n <= !w;
        addr <= a;
        data_in <= d;
        lane_en_n <= l;
        repeat (2) @(posedge core_clk);
        #1 q = data_out;
        @(posedge core_clk);
        cs_n <= 1'b1;
        rd_n <= 1'b1;
        wr_n <= 1'b1;
        addr <= ~a;
        data_in <= ~d;
        lane_en_n <= 2'b11;
        @(posedge core_clk);
    endtask
endmodule

/* File: dv/test_hpb_regs.sv */
`timescale 1ns/10ps
module test_hpb_regs;
    logic core_clk = 1'b0;
    logic reset = 1'b1;
    logic cs_n, rd_n, wr_n, data_oe, irq_out_n, macro_rst, le_act, width, mode;
    logic [1:0]  lane_en_n, power_state;
    logic [7:0]  addr, clk_sel;
    logic [15:0] data_in, data_out, q;
    int err_total = 0;
    int samples_checked = 0;
    int n;
    localparam logic [15:0] TMR [4] = '{16'hA55A, 16'h5AA5, 16'h2500, 16'h0010};
    localparam logic [7:0]  CFG [5] = '{8'h00, 8'h04, 8'h02, 8'h06, 8'h01};
    localparam logic [7:0]  SEL [5] = '{8'h00, 8'h80, 8'h01, 8'h81, 8'h83};
    always #2.5 core_clk = ~core_clk;
    hpb_host_model hpb_host_model_inst (.core_clk(core_clk), .data_out(data_out), .cs_n(cs_n),
        .rd_n(rd_n), .wr_n(wr_n), .lane_en_n(lane_en_n), .addr(addr), .data_in(data_in));
    hpb_regs hpb_regs_inst (.core_clk(core_clk), .reset(reset), .cs_n(cs_n), .rd_n(rd_n),
        .wr_n(wr_n), .lane_en_n(lane_en_n), .addr(addr), .data_in(data_in), .data_out(data_out),
        .data_oe(data_oe), .irq_out_n(irq_out_n), .transceiver_macro_reset(macro_rst),
        .little_endian_active(le_act), .bus_width_select(width),
        .strobe_or_byte_enable_select(mode), .clock_input_select(clk_sel),
        .power_state(power_state));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic [1:0] l);
        hpb_host_model_inst.access(a, d, l, 1'b1, q);
    endtask
    task automatic rd(input logic [7:0] a);
        hpb_host_model_inst.access(a, 16'h0000, 2'b11, 1'b0, q);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (2) @(posedge core_clk);
        reset <= 1'b0;
        wr(8'h14, 16'h1234, 2'b00);
        rd(8'h14);
        check(q, 16'h0000);
        rd(8'h12);
        check({14'h0, power_state}, 16'h0001);
        wr(8'h80, 16'hFFFF, 2'b00);
        rd(8'h80);
        check(q, 16'h0000);
        foreach (TMR[i]) begin
            wr(8'h14, TMR[i], 2'b00);
            rd(8'h14);
            check(q, TMR[i]);
        end
        // One whole byte per write, odd lane in big-endian order
        foreach (CFG[i]) begin
            wr(8'h75, {8'h00, CFG[i]}, 2'b10);
            check({13'h0, le_act, mode, width}, {14'h0, CFG[i][1:0]});
        end
        // Last setting leaves the bus narrow: one byte on the low lane
        rd(8'h75);
        check(q, 16'h0001);
        wr(8'h75, 16'h0000, 2'b10);
        wr(8'h74, 16'h0400, 2'b01);
        rd(8'h74);
        check(q, 16'h0404);
        check({15'h0, le_act}, 16'h0000);
        rd(8'h76);
        check({15'h0, le_act}, 16'h0001);
        wr(8'h74, 16'h0000, 2'b00);
        rd(8'h76);
        check({15'h0, le_act}, 16'h0000);
        foreach (SEL[i]) begin
            wr(8'h73, {8'h00, SEL[i]}, 2'b10);
            rd(8'h72);
            check(q, {8'h00, SEL[i]});
        end
        wr(8'h71, 16'h0000, 2'b10);
        wr(8'h73, 16'h0001, 2'b10);
        check({8'h00, clk_sel}, 16'h0083);
        rd(8'h40);
        check(q, 16'h0000);
        check({15'h0, macro_rst}, 16'h0001);
        wr(8'h11, 16'h0000, 2'b10);
        check({15'h0, macro_rst}, 16'h0000);
        wr(8'h12, 16'h4000, 2'b01);
        check({14'h0, power_state}, 16'h0002);
        for (n = 0; n < 4000 && power_state !== 2'h3; n++)
            @(posedge core_clk);
        #1;
        if (n == 4000) begin
            err_total++;
        end
        check({14'h0, power_state}, 16'h0003);
        rd(8'h00);
        check(q, 16'h0100);
        check({15'h0, irq_out_n}, 16'h0001);
        wr(8'h08, 16'h0100, 2'b01);
        check({15'h0, irq_out_n}, 16'h0000);
        wr(8'h08, 16'h0000, 2'b01);
        check({15'h0, irq_out_n}, 16'h0001);
        wr(8'h00, 16'h0100, 2'b01);
        rd(8'h00);
        check(q, 16'h0000);
        wr(8'h80, 16'hFFFF, 2'b00);
        rd(8'h80);
        check(q, 16'h1FFC);
        wr(8'hC6, 16'hFFFF, 2'b00);
        rd(8'hC6);
        check(q, 16'h7F7F);
        complete_run();
    end
endmodule
